// *** core/srl_pkg.sv ***
// package: constants and types for the serial rom loader and its bus
package srl_pkg;
    // timing
    localparam int CLK_PERIOD_NS     = 100;
    localparam int ROM_CLK_PERIOD_NS = 800;
    localparam int QUARTER_CYCLES    =
        (ROM_CLK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    // widths
    localparam int WORD_W     = 16;
    localparam int WADDR_W    = 7;
    localparam int BADDR_W    = 8;
    localparam int IRQ_W      = 3;
    localparam int REGION_W   = 4;
    // two-wire control byte
    localparam logic [3:0] DEV_TYPE_CODE = 4'h0a;
    localparam logic [2:0] DEV_SELECT    = 3'h0;
    // rom image layout
    localparam logic [15:0] SIGNATURE      = 16'h1516;
    localparam logic [6:0]  SIG_WORD       = 7'h00;
    localparam logic [6:0]  REGION_WORD    = 7'h01;
    localparam int          REGION_LSB     = 1;
    localparam int          WP_BIT         = 8;
    localparam logic [3:0]  REGION_GROUP1  = 4'h0;
    localparam logic [3:0]  REGION_GROUP2  = 4'h1;
    localparam logic [3:0]  REGION_GROUP3  = 4'h3;
    localparam logic [3:0]  REGION_GROUP4  = 4'h7;
    localparam logic [3:0]  REGION_GROUP5  = 4'hf;
    localparam logic [6:0]  LAST_WORD_G1   = 7'h01;
    localparam logic [6:0]  LAST_WORD_G2   = 7'h09;
    localparam logic [6:0]  LAST_WORD_G3   = 7'h11;
    localparam logic [6:0]  LAST_WORD_G4   = 7'h13;
    localparam logic [6:0]  LAST_WORD_G5   = 7'h1f;
    // sequence steps
    localparam logic [2:0] RX_LO_STEP   = 3'h5;
    localparam logic [2:0] RX_LAST_STEP = 3'h6;
    // register offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_WDATA      = 8'h04;
    localparam logic [7:0] REG_RDATA      = 8'h08;
    localparam logic [7:0] REG_STATUS     = 8'h0c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_ADDR_LSB  = 8;
    localparam int ST_CYCLE_BIT   = 0;
    localparam int ST_BUSY_BIT    = 1;
    localparam int ST_WP_BIT      = 2;
    localparam int ST_REGION_LSB  = 4;
    localparam int IRQ_USER_DONE  = 0;
    localparam int IRQ_LOAD_DONE  = 1;
    localparam int IRQ_NACK       = 2;
    // reset values
    localparam logic [2:0]  IRQ_ENABLE_RESET = 3'h0;
    localparam logic [15:0] WORD_RESET       = 16'h0000;

    typedef enum logic [6:0] {
        B_IDLE  = 7'h01,
        B_START = 7'h02,
        B_TX    = 7'h04,
        B_TACK  = 7'h08,
        B_RX    = 7'h10,
        B_RACK  = 7'h20,
        B_STOP  = 7'h40
    } srl_bit_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_SIG  = 4'h2,
        M_LOAD = 4'h4,
        M_USER = 4'h8
    } srl_mode_t;

    function automatic logic [7:0] srl_rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : srl_rev8
endpackage : srl_pkg

// *** core/srl_autoload.sv ***
// module: serial rom boot loader, auto-mode sequencer and apb registers
`timescale 1ns/1ns
module srl_autoload #(
    parameter int QUARTER = srl_pkg::QUARTER_CYCLES
) (
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [31:0]                        prdata,
    // bridge pins
    input  wire logic                          primary_reset_in_n,
    input  wire logic                          serial_rom_enable_n,
    output logic                               serial_rom_clock,
    input  wire logic                          serial_rom_data_in,
    output logic                               serial_rom_data_out,
    output logic                               serial_rom_data_oe_n,
    // configuration register load port
    output logic                               cfg_wr_strobe,
    output logic [srl_pkg::BADDR_W-1:0]        cfg_wr_rom_addr,
    output logic [srl_pkg::WORD_W-1:0]         cfg_wr_data,
    output logic                               isa_enable_write_protect,
    // status and interrupt
    output logic                               autoload_busy,
    output logic                               irq
);
    import srl_pkg::*;

    localparam int QW = $clog2(QUARTER + 1);

    // synchronisers
    logic              prst_meta;
    logic              prst_sync;
    logic              prst_seen;
    logic              en_meta;
    logic              en_sync;
    logic              sda_meta;
    logic              sda_sync;
    // bit engine
    logic [QW-1:0]     qcnt;
    srl_bit_t          bstate;
    logic [1:0]        phase;
    logic [2:0]        bitcnt;
    logic [2:0]        step;
    logic [7:0]        shift;
    logic [7:0]        rx_lo;
    logic [7:0]        rx_hi;
    logic              got_nack;
    // loader
    srl_mode_t         mode;
    logic [6:0]        job_word;
    logic              job_write;
    logic [15:0]       job_wdata;
    logic [3:0]        region_code;
    // registers
    logic              ctrl_write;
    logic [6:0]        ctrl_addr;
    logic [15:0]       wdata_reg;
    logic [15:0]       rdata_reg;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_enable;

    function automatic srl_bit_t op_state(input logic [2:0] s,
                                          input logic       wr);
        srl_bit_t r;
        r = B_STOP;
        if (wr) begin
            if (s == 3'h0) begin
                r = B_START;
            end else if (s <= 3'h4) begin
                r = B_TX;
            end
        end else begin
            unique case (s)
                3'h0, 3'h3: r = B_START;
                3'h1, 3'h2, 3'h4: r = B_TX;
                3'h5, 3'h6: r = B_RX;
                default: r = B_STOP;
            endcase
        end
        return r;
    endfunction : op_state

    function automatic logic [6:0] last_of(input logic [3:0] code);
        logic [6:0] r;
        unique case (code)
            REGION_GROUP2: r = LAST_WORD_G2;
            REGION_GROUP3: r = LAST_WORD_G3;
            REGION_GROUP4: r = LAST_WORD_G4;
            REGION_GROUP5: r = LAST_WORD_G5;
            // undefined codes load nothing beyond the header
            default:       r = LAST_WORD_G1;
        endcase
        return r;
    endfunction : last_of

    // pin inputs pass two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prst_meta <= 1'b0;
            prst_sync <= 1'b0;
            prst_seen <= 1'b0;
            en_meta   <= 1'b1;
            en_sync   <= 1'b1;
            sda_meta  <= 1'b1;
            sda_sync  <= 1'b1;
        end else begin
            prst_meta <= primary_reset_in_n;
            prst_sync <= prst_meta;
            prst_seen <= prst_sync;
            en_meta   <= serial_rom_enable_n;
            en_sync   <= en_meta;
            sda_meta  <= serial_rom_data_in;
            sda_sync  <= sda_meta;
        end
    end

    // quarter-bit ticks for the divided rom clock
    wire tick = (qcnt == QW'(QUARTER - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qcnt <= '0;
        end else begin
            qcnt <= tick ? '0 : qcnt + QW'(1);
        end
    end

    // decode of engine events
    wire       ph_end   = tick & (phase == 2'd3);
    wire       eng_done = ph_end & (bstate == B_STOP) & prst_sync;
    wire [2:0] step_nx  = step + 3'd1;
    wire [15:0] rom_word = {rx_hi, rx_lo};
    wire [7:0] dev_wr = {DEV_TYPE_CODE, DEV_SELECT, 1'b0};
    wire [7:0] dev_rd = {DEV_TYPE_CODE, DEV_SELECT, 1'b1};
    // word address doubled into byte address
    wire [7:0] byte_addr = {job_word, 1'b0};
    // data bytes go out lsb first
    wire [7:0] tx_lo = srl_rev8(job_wdata[7:0]);
    wire [7:0] tx_hi = srl_rev8(job_wdata[15:8]);
    wire [7:0] next_tx =
        (step_nx == 3'h1) ? dev_wr :
        (step_nx == 3'h2) ? byte_addr :
        (step_nx == 3'h3) ? tx_lo :
        (step_nx == 3'h4) ? (job_write ? tx_hi : dev_rd) : 8'h00;

    // loader decisions
    wire sig_done  = eng_done & (mode == M_SIG);
    wire load_fin  = eng_done & (mode == M_LOAD);
    wire user_done = eng_done & (mode == M_USER);
    // boot read on primary reset release
    wire prst_rise = prst_sync & ~prst_seen;
    wire boot_go   = prst_rise & ~en_sync;
    // disabled rom ends busy at once
    wire boot_skip = prst_rise & en_sync;
    wire sig_ok    = sig_done & ~got_nack & (rom_word == SIGNATURE);
    wire [3:0] region_now = (job_word == REGION_WORD) ?
        rom_word[REGION_LSB +: REGION_W] : region_code;
    wire [6:0] stop_word  = last_of(region_now);
    wire load_more = load_fin & ~got_nack & (job_word != stop_word);
    wire load_end  = load_fin & ~load_more;
    wire cfg_fire  = load_fin & ~got_nack & (job_word > REGION_WORD);

    // apb decode
    wire sel_ctrl   = (paddr == REG_CTRL);
    wire sel_wdata  = (paddr == REG_WDATA);
    wire sel_rdata  = (paddr == REG_RDATA);
    wire sel_status = (paddr == REG_STATUS);
    wire sel_ist    = (paddr == REG_IRQ_STATUS);
    wire sel_iclr   = (paddr == REG_IRQ_CLEAR);
    wire sel_ien    = (paddr == REG_IRQ_ENABLE);
    wire mapped     = sel_ctrl | sel_wdata | sel_rdata | sel_status |
                      sel_ist | sel_iclr | sel_ien;
    wire bad_access = ~mapped | (autoload_busy & ~sel_status);
    wire setup      = psel & ~penable;
    wire wr_ok      = psel & penable & pready & pwrite & ~pslverr;
    wire cycle_busy = (mode == M_USER);
    // start ignored while a cycle runs
    wire user_start = wr_ok & sel_ctrl & pwdata[CTRL_START_BIT] &
                      (mode == M_IDLE) & ~autoload_busy & ~en_sync;
    wire eng_go     = boot_go | sig_ok | load_more | user_start;

    wire [31:0] status_word =
        (32'(cycle_busy) << ST_CYCLE_BIT) |
        (32'(autoload_busy) << ST_BUSY_BIT) |
        (32'(isa_enable_write_protect) << ST_WP_BIT) |
        (32'(region_code) << ST_REGION_LSB);
    wire [31:0] rd_word =
        sel_ctrl   ? ((32'(ctrl_addr) << CTRL_ADDR_LSB) |
                      (32'(ctrl_write) << CTRL_WRITE_BIT)) :
        sel_wdata  ? 32'(wdata_reg) :
        sel_rdata  ? 32'(rdata_reg) :
        sel_status ? status_word :
        sel_ist    ? 32'(irq_status) :
        sel_ien    ? 32'(irq_enable) : 32'h0000_0000;

    wire [IRQ_W-1:0] irq_set =
        (IRQ_W'(user_done) << IRQ_USER_DONE) |
        (IRQ_W'(load_end | (sig_done & ~sig_ok)) << IRQ_LOAD_DONE) |
        (IRQ_W'(eng_done & got_nack) << IRQ_NACK);
    wire [IRQ_W-1:0] irq_clr =
        (wr_ok & sel_iclr) ? pwdata[IRQ_W-1:0] : '0;

    // clock and open-drain data from engine phase
    wire next_scl = (bstate == B_IDLE) |
        ((bstate == B_STOP) ? (phase != 2'd0) :
                              (phase == 2'd1 || phase == 2'd2));
    // start and stop edges while clock high
    wire next_sda_rel =
        (bstate == B_START) ? (phase < 2'd2) :
        (bstate == B_STOP)  ? (phase >= 2'd2) :
        (bstate == B_TX)    ? shift[7] :
        (bstate == B_RACK)  ? (step == RX_LAST_STEP) : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bstate   <= B_IDLE;
            phase    <= 2'd0;
            bitcnt   <= 3'd0;
            step     <= 3'd0;
            shift    <= 8'h00;
            rx_lo    <= 8'h00;
            rx_hi    <= 8'h00;
            got_nack <= 1'b0;
        end else if (eng_go) begin
            bstate   <= B_START;
            phase    <= 2'd0;
            step     <= 3'd0;
            got_nack <= 1'b0;
        end else if (tick && bstate != B_IDLE) begin
            phase <= phase + 2'd1;
            unique case (bstate)
                B_IDLE: begin
                end
                B_TX, B_RX: begin
                    if (bstate == B_RX && phase == 2'd2) begin
                        shift <= {shift[6:0], sda_sync};
                    end
                    if (phase == 2'd3) begin
                        if (bstate == B_TX) begin
                            shift <= {shift[6:0], 1'b0};
                        end
                        bitcnt <= bitcnt + 3'd1;
                        if (bitcnt == 3'd7) begin
                            bstate <= (bstate == B_TX) ? B_TACK : B_RACK;
                        end
                    end
                end
                B_STOP: begin
                    if (phase == 2'd3) begin
                        bstate <= B_IDLE;
                    end
                end
                B_START, B_TACK, B_RACK: begin
                    if (bstate == B_TACK && phase == 2'd2 && sda_sync) begin
                        got_nack <= 1'b1;
                    end
                    if (phase == 2'd3) begin
                        // low byte first, reversed data bits
                        if (bstate == B_RACK && step == RX_LO_STEP) begin
                            rx_lo <= srl_rev8(shift);
                        end else if (bstate == B_RACK) begin
                            rx_hi <= srl_rev8(shift);
                        end
                        bitcnt <= 3'd0;
                        step   <= step_nx;
                        shift  <= next_tx;
                        bstate <= (bstate == B_TACK && got_nack) ?
                                  B_STOP : op_state(step_nx, job_write);
                    end
                end
            endcase
        end
    end

    // sequencer for boot load and auto mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode        <= M_IDLE;
            job_word    <= SIG_WORD;
            job_write   <= 1'b0;
            job_wdata   <= WORD_RESET;
            region_code <= REGION_GROUP1;
            rdata_reg   <= WORD_RESET;
            isa_enable_write_protect <= 1'b0;
            // busy until the boot decision is made
            autoload_busy <= 1'b1;
        end else if (!prst_sync) begin
            mode          <= M_IDLE;
            autoload_busy <= 1'b1;
        end else if (boot_go) begin
            mode      <= M_SIG;
            job_word  <= SIG_WORD;
            job_write <= 1'b0;
        end else if (boot_skip || (sig_done && !sig_ok)) begin
            mode          <= M_IDLE;
            autoload_busy <= 1'b0;
        end else if (sig_ok) begin
            mode     <= M_LOAD;
            job_word <= REGION_WORD;
        end else if (load_fin) begin
            if (job_word == REGION_WORD && !got_nack) begin
                region_code <= region_now;
                isa_enable_write_protect <= rom_word[WP_BIT];
            end
            if (load_more) begin
                job_word <= job_word + 7'd1;
            end else begin
                // busy clears at end of load
                mode          <= M_IDLE;
                autoload_busy <= 1'b0;
            end
        end else if (user_done) begin
            mode <= M_IDLE;
            if (!job_write && !got_nack) begin
                rdata_reg <= rom_word;
            end
        end else if (user_start) begin
            mode      <= M_USER;
            job_word  <= pwdata[CTRL_ADDR_LSB +: WADDR_W];
            job_write <= pwdata[CTRL_WRITE_BIT];
            job_wdata <= wdata_reg;
        end
    end

    // loaded word to its configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_wr_strobe   <= 1'b0;
            cfg_wr_rom_addr <= 8'h00;
            cfg_wr_data     <= WORD_RESET;
        end else begin
            cfg_wr_strobe <= cfg_fire;
            if (cfg_fire) begin
                cfg_wr_rom_addr <= byte_addr;
                cfg_wr_data     <= rom_word;
            end
        end
    end

    // pin outputs, data low only when driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_rom_clock     <= 1'b1;
            serial_rom_data_out  <= 1'b0;
            serial_rom_data_oe_n <= 1'b1;
        end else begin
            serial_rom_clock     <= next_scl;
            serial_rom_data_out  <= 1'b0;
            serial_rom_data_oe_n <= next_sda_rel;
        end
    end

    // apb: answer one cycle after setup, data held in flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            ctrl_write <= 1'b0;
            ctrl_addr  <= 7'h00;
            wdata_reg  <= WORD_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end else begin
            pready  <= setup;
            pslverr <= setup & bad_access;
            prdata  <= (setup && !pwrite && !bad_access) ? rd_word : 32'h0;
            if (wr_ok && sel_ctrl) begin
                ctrl_write <= pwdata[CTRL_WRITE_BIT];
                ctrl_addr  <= pwdata[CTRL_ADDR_LSB +: WADDR_W];
            end
            if (wr_ok && sel_wdata) begin
                wdata_reg <= pwdata[15:0];
            end
            if (wr_ok && sel_ien) begin
                irq_enable <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // sticky events: a set in the clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq        <= |(irq_status & irq_enable);
        end
    end
endmodule : srl_autoload

// *** dv/srl_rom_model.sv ***
// partner: two-wire 256x8 serial memory
`timescale 1ns/1ns
module srl_rom_model (
    // wire side
    input  wire logic scl,
    input  wire logic sda,
    // fault control and data pull-down
    input  wire logic mute,
    output logic      pull
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       act, rd, tx;
    logic [3:0] nb, nbyte;
    initial {pull, act, rd, tx} = 4'h0;
    always @(negedge sda) if (scl) {act, rd, tx, nb, nbyte} = 11'h400;
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) begin
        if (act && nb < 4'h8 && !tx) sh = {sh[6:0], sda};
        if (act && nb == 4'h8 && tx && sda) act = 1'b0;
        nb = (nb == 4'h8) ? 4'h0 : nb + 4'h1;
    end
    always @(negedge scl) begin
        if (!act) pull = 1'b0;
        else if (nb == 4'h8 && !tx) begin
            pull = !mute && (nbyte != 4'h0 || sh[7:1] == 7'h50);
            if (nbyte == 4'h0) rd = sh[0];
            else if (nbyte == 4'h1) ptr = sh;
            else begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            nbyte = nbyte + 4'h1;
        end else if (nb == 4'h0 && rd) begin
            tx = 1'b1;
            sh = mem[ptr];
            ptr = ptr + 8'h01;
            pull = !sh[7];
        end else pull = tx && nb < 4'h8 && !sh[4'h7 - nb];
    end
endmodule : srl_rom_model

// *** dv/srl_autoload_assertions.sv ***
// checker: port properties of the loader
`timescale 1ns/1ns
module srl_autoload_checker (
    // clock, reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // loader
    input wire logic        primary_reset_in_n,
    input wire logic        serial_rom_clock,
    input wire logic        serial_rom_data_out,
    input wire logic        serial_rom_data_oe_n,
    input wire logic        cfg_wr_strobe,
    input wire logic [7:0]  cfg_wr_rom_addr,
    input wire logic        autoload_busy
);
    import srl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       seen;
    logic [7:0] prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seen <= 1'b0;
        else seen <= cfg_wr_strobe | (seen & autoload_busy);
    end
    always_ff @(posedge pclk) begin
        if (cfg_wr_strobe) prev <= cfg_wr_rom_addr;
    end
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_gate; pready && autoload_busy && $past(autoload_busy)
        && paddr != REG_STATUS |-> pslverr; endproperty
    a_gate: assert property (p_gate) else $error("busy ungated");
    property p_errz; pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_errz: assert property (p_errz) else $error("error data");
    property p_dout; serial_rom_data_out == 1'b0; endproperty
    a_dout: assert property (p_dout) else $error("data driven");
    // data may only move while the rom clock holds still
    property p_hold; $changed(serial_rom_clock) |->
        $stable(serial_rom_data_oe_n); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_rclk; $rose(serial_rom_clock) |-> serial_rom_clock[*4];
    endproperty
    a_rclk: assert property (p_rclk) else $error("clock high");
    property p_busy; (!primary_reset_in_n)[*3] |=> autoload_busy; endproperty
    a_busy: assert property (p_busy) else $error("busy low");
    property p_spul; cfg_wr_strobe |=> !cfg_wr_strobe; endproperty
    a_spul: assert property (p_spul) else $error("strobe long");
    property p_asc; cfg_wr_strobe |->
        cfg_wr_rom_addr == (seen ? prev + 8'h02 : 8'h04); endproperty
    a_asc: assert property (p_asc) else $error("load order");
endmodule : srl_autoload_checker

// *** dv/srl_autoload_tb.sv ***
// bench: boot load, auto mode, registers
`timescale 1ns/1ns
module srl_autoload_tb;
    import srl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        prst_n, en_n, rclk, dout, oe_n, stb, wp, busy, irq;
    logic        pull, mute, e;
    logic [7:0]  paddr, saddr, ea;
    logic [15:0] sdata;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, n_compared, nstb, i;
    // open drain with pull-up
    wire         sda = !((!oe_n && !dout) || pull);
    srl_autoload uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .primary_reset_in_n(prst_n),
        .serial_rom_enable_n(en_n), .serial_rom_clock(rclk),
        .serial_rom_data_in(sda), .serial_rom_data_out(dout),
        .serial_rom_data_oe_n(oe_n), .cfg_wr_strobe(stb),
        .cfg_wr_rom_addr(saddr), .cfg_wr_data(sdata),
        .isa_enable_write_protect(wp), .autoload_busy(busy), .irq(irq));
    srl_rom_model rom (.scl(rclk), .sda(sda), .mute(mute), .pull(pull));
    function automatic logic [7:0] flip(input logic [7:0] b);
        for (int k = 0; k < 8; k++) flip[k] = b[7 - k];
    endfunction : flip
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (i == 20) begin
            mismatches++;
            final_report();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input logic xe);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rdc
    task automatic wait_idle;
        int n;
        for (n = 0; n < 3000; n++) begin
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            if (rd[ST_CYCLE_BIT] === 1'b0 && rd[ST_BUSY_BIT] === 1'b0) break;
        end
        if (n == 3000) begin
            mismatches++;
            final_report();
        end
    endtask : wait_idle
    task automatic reboot;
        prst_n <= 1'b0;
        repeat (6) @(posedge pclk);
        prst_n <= 1'b1;
        wait_idle();
    endtask : reboot
    always @(posedge pclk) begin
        if (stb === 1'b1) begin
            check({24'h0, saddr}, {24'h0, ea});
            check({16'h0, sdata}, {16'h0, ea + 8'h01, ea});
            ea = ea + 8'h02;
            nstb++;
        end
    end
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, prst_n, en_n, mute} = 4'h0;
        {mismatches, n_compared, nstb} = '0;
        ea = 8'h04;
        for (int k = 0; k < 256; k++)
            rom.mem[k] = k < 36 ? flip(8'(k)) : 8'h00;
        rom.mem[0] = flip(8'h16);
        rom.mem[1] = flip(8'h15);
        rom.mem[2] = flip(8'h02);
        rom.mem[3] = flip(8'h01);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(REG_CTRL, 32'h0000_0000, 1'b1);
        rdc(REG_STATUS, 32'h0000_0002, 1'b0);
        prst_n <= 1'b1;
        wait_idle();
        check(32'(nstb), 32'h0000_0008);
        check({31'h0, wp}, 32'h0000_0001);
        rdc(REG_STATUS, 32'h0000_0014, 1'b0);
        rdc(REG_IRQ_STATUS, 32'h0000_0002, 1'b0);
        rdc(8'h1c, 32'h0000_0000, 1'b1);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, REG_IRQ_ENABLE, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, REG_IRQ_CLEAR, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, REG_WDATA, 32'h0000_a55a);
        apb(1'b1, REG_CTRL, 32'h0000_3003);
        wait_idle();
        check({24'h0, rom.mem[8'h60]}, {24'h0, flip(8'h5a)});
        check({24'h0, rom.mem[8'h61]}, {24'h0, flip(8'ha5)});
        apb(1'b1, REG_CTRL, 32'h0000_3001);
        wait_idle();
        rdc(REG_RDATA, 32'h0000_a55a, 1'b0);
        rdc(REG_IRQ_STATUS, 32'h0000_0001, 1'b0);
        mute <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h0000_0501);
        wait_idle();
        rdc(REG_IRQ_STATUS, 32'h0000_0005, 1'b0);
        rdc(REG_RDATA, 32'h0000_a55a, 1'b0);
        mute <= 1'b0;
        en_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        rdc(REG_STATUS, 32'h0000_0014, 1'b0);
        reboot();
        check(32'(nstb), 32'h0000_0008);
        // bad signature: no load, busy ends, values kept
        en_n <= 1'b0;
        rom.mem[1] = 8'h00;
        reboot();
        check(32'(nstb), 32'h0000_0008);
        rdc(REG_IRQ_STATUS, 32'h0000_0007, 1'b0);
        rdc(REG_STATUS, 32'h0000_0014, 1'b0);
        apb(1'b1, REG_IRQ_CLEAR, 32'h0000_0007);
        // region code 0011 stops after word 11h
        rom.mem[1] = flip(8'h15);
        rom.mem[2] = flip(8'h06);
        ea = 8'h04;
        reboot();
        check(32'(nstb), 32'h0000_0018);
        rdc(REG_STATUS, 32'h0000_0034, 1'b0);
        rdc(REG_IRQ_STATUS, 32'h0000_0002, 1'b0);
        final_report();
    end
endmodule : srl_autoload_tb
bind srl_autoload srl_autoload_checker chk (.pclk, .presetn, .psel,
    .penable, .paddr, .pready, .pslverr, .prdata, .primary_reset_in_n,
    .serial_rom_clock, .serial_rom_data_out, .serial_rom_data_oe_n,
    .cfg_wr_strobe, .cfg_wr_rom_addr, .autoload_busy);
